// ==== hw/pca_regs_cfg.svh ====
// Address map, field positions and reset values
// for the counter and capture/compare register block.
// Assumes an 8-bit special-function-register bus on the core clock.
`ifndef PCA_REGS_CFG_SVH
`define PCA_REGS_CFG_SVH

// ==========================================================
// Register addresses
`define ADDR_COUNTER_LOW   8'hf9
`define ADDR_COUNTER_HIGH  8'hfa
`define ADDR_CAPTURE0_LOW  8'hfb
`define ADDR_CAPTURE0_HIGH 8'hfc
`define ADDR_CAPTURE1_LOW  8'he9
`define ADDR_CAPTURE1_HIGH 8'hea
`define ADDR_CAPTURE2_LOW  8'heb
`define ADDR_CAPTURE2_HIGH 8'hec
`define ADDR_CAPTURE3_LOW  8'hed
`define ADDR_CAPTURE3_HIGH 8'hee
`define ADDR_CAPTURE4_LOW  8'hfd
`define ADDR_CAPTURE4_HIGH 8'hfe
`define ADDR_CAPTURE5_LOW  8'hd2
`define ADDR_CAPTURE5_HIGH 8'hd3
`define ADDR_MODULE0_MODE  8'hda
`define ADDR_MODULE1_MODE  8'hdb
`define ADDR_MODULE2_MODE  8'hdc
`define ADDR_MODULE3_MODE  8'hdd
`define ADDR_MODULE4_MODE  8'hde
`define ADDR_MODULE5_MODE  8'hce

// ==========================================================
// Fields and reset values
`define MODE_WIDE_PWM_BIT  7
`define MODE_COMPARE_BIT   6
`define MODE_PWM_BIT       1
`define WATCHDOG_MODULE    3'h5
`define RESET_BYTE         8'h00
`define RESET_WORD         16'h0000
`define UNMAPPED_READ      8'h00

`endif

// ==== hw/pca_regs_pkg.sv ====
// Types shared by the counter and capture/compare register block.
// Assumes nothing beyond a SystemVerilog compiler.
`default_nettype none
package pca_regs_pkg;

	typedef logic [7:0]  sfr_byte_t;
	typedef logic [15:0] count_word_t;

	// Cycle length when a channel is not in 16-bit PWM mode
	typedef enum logic [1:0] {
		CYCLE_8  = 2'b00,
		CYCLE_9  = 2'b01,
		CYCLE_10 = 2'b10,
		CYCLE_11 = 2'b11
	} cycle_len_t;

endpackage

`default_nettype wire

// ==== hw/pca_counter_capture_regs.sv ====
// Counter/timer and six capture/compare modules behind the core's
// special-function-register port, with mode registers and auto-reload.
// Assumes a single-cycle SFR bus on CORE_CLK and watchdog, reload select
// and cycle length driven by logic on the same clock.
`timescale 1ns/100ps
`include "pca_regs_cfg.svh"
`default_nettype none

// Operation
// - Counter low byte register is count bits 7:0, readable and writable.
// - Counter high byte register maps to count bits 15:8.
// - High byte reads return a snapshot taken when the low byte is read.
// - Low byte writes are ignored while the watchdog is enabled.
// - High byte writes are ignored while the watchdog is enabled.
// - Six modules each hold a 16-bit value as low and high byte registers.
// - With reload select set, the low address reaches the auto-reload low byte.
// - With reload select set, the high address reaches the auto-reload high byte.
// - Writing a module's low byte clears its comparator enable.
// - Writing a module's high byte sets its comparator enable.
// - Comparator enable turns on the module's comparator; other mode bits pick function.
// - While watchdog is enabled, module 5's mode register cannot change.
// - Cycle length field picks 8, 9, 10 or 11 bit cycles outside 16-bit PWM.
module pca_counter_capture_regs
	import pca_regs_pkg::*;
(
	input  wire logic        CORE_CLK,
	input  wire logic        RST_N,
	input  wire logic        CLK_EN,
	input  wire logic [7:0]  SFR_ADDR,
	input  wire logic        SFR_WR,
	input  wire logic        SFR_RD,
	input  wire logic [7:0]  SFR_WDATA,
	output var  logic [7:0]  SFR_RDATA,
	output var  logic        SFR_RVALID,
	input  wire logic        COUNT_TICK,
	input  wire logic        WATCHDOG_ENABLE,
	input  wire logic        RELOAD_SELECT,
	input  wire logic [1:0]  CYCLE_LENGTH_SELECT,
	output var  logic [15:0] COUNT_VALUE,
	output var  logic        CYCLE_WRAP,
	output var  logic [5:0]  COMPARATOR_ENABLE,
	output var  logic [5:0]  MATCH
);

	localparam int CHANNELS = 6;

	// ==========================================================
	// Address decode
	// Result: [4] hit, [3] high byte, [2:0] module index
	function automatic logic [4:0] capture_slot(input logic [7:0] addr);
		begin
			unique case (addr)
				`ADDR_CAPTURE0_LOW:  capture_slot = 5'b10_000;
				`ADDR_CAPTURE0_HIGH: capture_slot = 5'b11_000;
				`ADDR_CAPTURE1_LOW:  capture_slot = 5'b10_001;
				`ADDR_CAPTURE1_HIGH: capture_slot = 5'b11_001;
				`ADDR_CAPTURE2_LOW:  capture_slot = 5'b10_010;
				`ADDR_CAPTURE2_HIGH: capture_slot = 5'b11_010;
				`ADDR_CAPTURE3_LOW:  capture_slot = 5'b10_011;
				`ADDR_CAPTURE3_HIGH: capture_slot = 5'b11_011;
				`ADDR_CAPTURE4_LOW:  capture_slot = 5'b10_100;
				`ADDR_CAPTURE4_HIGH: capture_slot = 5'b11_100;
				`ADDR_CAPTURE5_LOW:  capture_slot = 5'b10_101;
				`ADDR_CAPTURE5_HIGH: capture_slot = 5'b11_101;
				default:             capture_slot = 5'b00_000;
			endcase
		end
	endfunction

	// Result: [3] hit, [2:0] module index
	function automatic logic [3:0] mode_slot(input logic [7:0] addr);
		begin
			unique case (addr)
				`ADDR_MODULE0_MODE: mode_slot = 4'b1_000;
				`ADDR_MODULE1_MODE: mode_slot = 4'b1_001;
				`ADDR_MODULE2_MODE: mode_slot = 4'b1_010;
				`ADDR_MODULE3_MODE: mode_slot = 4'b1_011;
				`ADDR_MODULE4_MODE: mode_slot = 4'b1_100;
				`ADDR_MODULE5_MODE: mode_slot = 4'b1_101;
				default:            mode_slot = 4'b0_000;
			endcase
		end
	endfunction

	// Bits of the count that make one PWM cycle
	function automatic logic [15:0] cycle_mask(input cycle_len_t sel);
		begin
			unique case (sel)
				CYCLE_8:  cycle_mask = 16'h00ff;
				CYCLE_9:  cycle_mask = 16'h01ff;
				CYCLE_10: cycle_mask = 16'h03ff;
				CYCLE_11: cycle_mask = 16'h07ff;
			endcase
		end
	endfunction

	// ==========================================================
	// State
	count_word_t count;
	sfr_byte_t   snapshot;
	count_word_t capture_value [CHANNELS];
	count_word_t reload_value  [CHANNELS];
	sfr_byte_t   module_mode   [CHANNELS];
	sfr_byte_t   next_rdata;
	count_word_t mask;

	logic       wr_en;
	logic       rd_en;
	logic [4:0] cap_slot;
	logic [3:0] md_slot;
	logic       cap_hit;
	logic       cap_high;
	logic [2:0] cap_idx;
	logic       md_hit;
	logic [2:0] md_idx;
	logic       wr_count_low;
	logic       wr_count_high;
	logic       wrap_now;

	assign wr_en    = CLK_EN && SFR_WR;
	assign rd_en    = CLK_EN && SFR_RD;
	assign cap_slot = capture_slot(SFR_ADDR);
	assign md_slot  = mode_slot(SFR_ADDR);
	assign cap_hit  = cap_slot[4];
	assign cap_high = cap_slot[3];
	assign cap_idx  = cap_slot[2:0];
	assign md_hit   = md_slot[3];
	assign md_idx   = md_slot[2:0];
	assign mask     = cycle_mask(cycle_len_t'(CYCLE_LENGTH_SELECT));
	assign wrap_now = COUNT_TICK && ((count & mask) == mask);

	// Watchdog owns the count; writes are dropped without any bus error
	assign wr_count_low  = wr_en && SFR_ADDR == `ADDR_COUNTER_LOW && !WATCHDOG_ENABLE;
	assign wr_count_high = wr_en && SFR_ADDR == `ADDR_COUNTER_HIGH && !WATCHDOG_ENABLE;

	// ==========================================================
	// Counter and high-byte snapshot
	// A software write in the same cycle as a tick wins; the tick is lost.
	always_ff @(posedge CORE_CLK or negedge RST_N)
	begin
		if (!RST_N)
			count <= `RESET_WORD;
		else if (CLK_EN)
		begin
			if (wr_count_low)
				count[7:0] <= SFR_WDATA;
			else if (wr_count_high)
				count[15:8] <= SFR_WDATA;
			else if (COUNT_TICK)
				count <= count + 16'h0001;
		end
	end

	// Latching on the low read keeps a 16-bit read coherent across two bytes
	always_ff @(posedge CORE_CLK or negedge RST_N)
	begin
		if (!RST_N)
			snapshot <= `RESET_BYTE;
		else if (rd_en && SFR_ADDR == `ADDR_COUNTER_LOW)
			snapshot <= count[15:8];
	end

	// ==========================================================
	// Mode registers and comparator enable side effects
	always_ff @(posedge CORE_CLK or negedge RST_N)
	begin
		if (!RST_N)
		begin
			for (int i = 0; i < CHANNELS; i++)
				module_mode[i] <= `RESET_BYTE;
		end
		else if (CLK_EN)
		begin
			for (int i = 0; i < CHANNELS; i++)
			begin
				// Module 5's mode register is frozen whole while it serves as watchdog
				if (!(WATCHDOG_ENABLE && i == int'(`WATCHDOG_MODULE)))
				begin
					if (wr_en && md_hit && md_idx == 3'(i))
						module_mode[i] <= SFR_WDATA;
					else if (wr_en && cap_hit && cap_idx == 3'(i) && !cap_high)
						module_mode[i][`MODE_COMPARE_BIT] <= 1'b0;
					else if (wr_en && cap_hit && cap_idx == 3'(i) && cap_high)
						module_mode[i][`MODE_COMPARE_BIT] <= 1'b1;
				end
			end
		end
	end

	// ==========================================================
	// Capture/compare values and auto-reload storage
	always_ff @(posedge CORE_CLK or negedge RST_N)
	begin
		if (!RST_N)
		begin
			for (int i = 0; i < CHANNELS; i++)
			begin
				capture_value[i] <= `RESET_WORD;
				reload_value[i]  <= `RESET_WORD;
			end
		end
		else if (CLK_EN)
		begin
			for (int i = 0; i < CHANNELS; i++)
			begin
				// Narrow PWM channels pick up their reload value at each cycle end
				if (wrap_now && module_mode[i][`MODE_PWM_BIT]
					&& !module_mode[i][`MODE_WIDE_PWM_BIT])
					capture_value[i] <= reload_value[i];
				if (wr_en && cap_hit && cap_idx == 3'(i))
				begin
					if (RELOAD_SELECT && !cap_high)
						reload_value[i][7:0] <= SFR_WDATA;
					else if (RELOAD_SELECT)
						reload_value[i][15:8] <= SFR_WDATA;
					else if (!cap_high)
						capture_value[i][7:0] <= SFR_WDATA;
					else
						capture_value[i][15:8] <= SFR_WDATA;
				end
			end
		end
	end

	// ==========================================================
	// Read path, one cycle after the strobe
	always_comb
	begin
		next_rdata = `UNMAPPED_READ;
		if (SFR_ADDR == `ADDR_COUNTER_LOW)
			next_rdata = count[7:0];
		else if (SFR_ADDR == `ADDR_COUNTER_HIGH)
			next_rdata = snapshot;
		else if (md_hit)
			next_rdata = module_mode[md_idx];
		else if (cap_hit && RELOAD_SELECT)
			next_rdata = cap_high ? reload_value[cap_idx][15:8]
				: reload_value[cap_idx][7:0];
		else if (cap_hit)
			next_rdata = cap_high ? capture_value[cap_idx][15:8]
				: capture_value[cap_idx][7:0];
	end

	always_ff @(posedge CORE_CLK or negedge RST_N)
	begin
		if (!RST_N)
		begin
			SFR_RDATA  <= `RESET_BYTE;
			SFR_RVALID <= 1'b0;
		end
		else if (CLK_EN)
		begin
			SFR_RVALID <= SFR_RD;
			if (SFR_RD)
				SFR_RDATA <= next_rdata;
		end
	end

	// ==========================================================
	// Comparator outputs
	always_ff @(posedge CORE_CLK or negedge RST_N)
	begin
		if (!RST_N)
		begin
			MATCH      <= 6'h00;
			CYCLE_WRAP <= 1'b0;
		end
		else if (CLK_EN)
		begin
			CYCLE_WRAP <= wrap_now;
			for (int i = 0; i < CHANNELS; i++)
			begin
				if (!module_mode[i][`MODE_COMPARE_BIT])
					MATCH[i] <= 1'b0;
				else if (module_mode[i][`MODE_WIDE_PWM_BIT])
					MATCH[i] <= count == capture_value[i];
				else
					MATCH[i] <= (count & mask) == (capture_value[i] & mask);
			end
		end
	end

	always_comb
	begin
		for (int i = 0; i < CHANNELS; i++)
			COMPARATOR_ENABLE[i] = module_mode[i][`MODE_COMPARE_BIT];
	end

	assign COUNT_VALUE = count;

	// ==========================================================
	// Assertions
	default clocking cb @(posedge CORE_CLK); endclocking
	default disable iff (!RST_N);

	AST_LOW_LOAD: assert property (
		wr_count_low |=> count[7:0] == $past(SFR_WDATA))
		else $error("Counter low byte not loaded by write");
	AST_HIGH_LOAD: assert property (
		wr_count_high |=> count[15:8] == $past(SFR_WDATA))
		else $error("Counter high byte not loaded by write");
	AST_SNAPSHOT_READ: assert property (
		rd_en && SFR_ADDR == `ADDR_COUNTER_LOW ##1 rd_en && SFR_ADDR == `ADDR_COUNTER_HIGH
		|=> SFR_RDATA == $past(count[15:8], 2))
		else $error("High byte read did not return snapshot");
	AST_WD_LOW_BLOCK: assert property (
		wr_en && SFR_ADDR == `ADDR_COUNTER_LOW && WATCHDOG_ENABLE && !COUNT_TICK
		|=> $stable(count))
		else $error("Low byte changed under watchdog");
	AST_WD_HIGH_BLOCK: assert property (
		wr_en && SFR_ADDR == `ADDR_COUNTER_HIGH && WATCHDOG_ENABLE && !COUNT_TICK
		|=> $stable(count))
		else $error("High byte changed under watchdog");
	AST_COMPARE_CLEAR: assert property (
		wr_en && SFR_ADDR == `ADDR_CAPTURE0_LOW |=> !COMPARATOR_ENABLE[0])
		else $error("Low byte write did not clear comparator enable");
	AST_COMPARE_SET: assert property (
		wr_en && SFR_ADDR == `ADDR_CAPTURE1_HIGH |=> COMPARATOR_ENABLE[1])
		else $error("High byte write did not set comparator enable");
	AST_MODE5_LOCK: assert property (
		CLK_EN && WATCHDOG_ENABLE |=> module_mode[5] == $past(module_mode[5]))
		else $error("Module 5 mode changed under watchdog");
	AST_RELOAD_ROUTE: assert property (
		wr_en && SFR_ADDR == `ADDR_CAPTURE0_LOW && RELOAD_SELECT
		|=> reload_value[0][7:0] == $past(SFR_WDATA) && ($stable(capture_value[0][7:0])
		|| $past(wrap_now)))
		else $error("Reload select did not route low byte");
	AST_MATCH_GATED: assert property (
		CLK_EN && !COMPARATOR_ENABLE[2] |=> !MATCH[2])
		else $error("Match raised with comparator disabled");
	AST_WRAP8: assert property (
		CLK_EN && CYCLE_LENGTH_SELECT == 2'b00 && COUNT_TICK && count[7:0] == 8'hff
		|=> CYCLE_WRAP)
		else $error("Eight-bit cycle end not flagged");

endmodule

`default_nettype wire

// ==== verif/pca_counter_capture_regs_tb.sv ====
// Self-checking bench for the counter and capture/compare register block.
// Assumes the block's package and address header are compiled first.
`timescale 1ns/100ps
`include "pca_regs_cfg.svh"
`default_nettype none
module pca_counter_capture_regs_tb;

	typedef struct packed
	{
		logic [7:0] a;
		logic [2:0] m;
		logic       hi;
	} row_t;

	logic        clk = 1'b0;
	logic        rst_n = 1'b0;
	logic        clk_en = 1'b1;
	logic        sfr_wr = 1'b0;
	logic        sfr_rd = 1'b0;
	logic        tick = 1'b0;
	logic        wde = 1'b0;
	logic        rsel = 1'b0;
	logic [7:0]  addr = 8'h00;
	logic [7:0]  wdata = 8'h00;
	logic [1:0]  clsel = 2'h0;
	logic [7:0]  rdata;
	logic        rvalid;
	logic        wrap;
	logic [15:0] count;
	logic [5:0]  cen;
	logic [5:0]  match;
	int          error_cnt = 0;
	int          total_checks = 0;
	int          cycles = 0;
	row_t        rows[12] = '{
		'{`ADDR_CAPTURE0_LOW, 3'd0, 1'b0}, '{`ADDR_CAPTURE0_HIGH, 3'd0, 1'b1},
		'{`ADDR_CAPTURE1_LOW, 3'd1, 1'b0}, '{`ADDR_CAPTURE1_HIGH, 3'd1, 1'b1},
		'{`ADDR_CAPTURE2_LOW, 3'd2, 1'b0}, '{`ADDR_CAPTURE2_HIGH, 3'd2, 1'b1},
		'{`ADDR_CAPTURE3_LOW, 3'd3, 1'b0}, '{`ADDR_CAPTURE3_HIGH, 3'd3, 1'b1},
		'{`ADDR_CAPTURE4_LOW, 3'd4, 1'b0}, '{`ADDR_CAPTURE4_HIGH, 3'd4, 1'b1},
		'{`ADDR_CAPTURE5_LOW, 3'd5, 1'b0}, '{`ADDR_CAPTURE5_HIGH, 3'd5, 1'b1}};

	pca_counter_capture_regs dut_u (
		.CORE_CLK            (clk),
		.RST_N               (rst_n),
		.CLK_EN              (clk_en),
		.SFR_ADDR            (addr),
		.SFR_WR              (sfr_wr),
		.SFR_RD              (sfr_rd),
		.SFR_WDATA           (wdata),
		.SFR_RDATA           (rdata),
		.SFR_RVALID          (rvalid),
		.COUNT_TICK          (tick),
		.WATCHDOG_ENABLE     (wde),
		.RELOAD_SELECT       (rsel),
		.CYCLE_LENGTH_SELECT (clsel),
		.COUNT_VALUE         (count),
		.CYCLE_WRAP          (wrap),
		.COMPARATOR_ENABLE   (cen),
		.MATCH               (match)
	);

	// ==========================================================
	// Clock, hang guard and shared tasks
	initial
	begin
		forever #2 clk = ~clk;
	end

	task automatic summarize;
		if (error_cnt == 0 && total_checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	// Whole run needs well under a thousand cycles
	always @(posedge clk)
	begin
		cycles++;
		if (cycles == 4000)
		begin
			error_cnt++;
			summarize();
		end
	end

	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		total_checks++;
		if (seen !== exp)
		begin
			error_cnt++;
			$display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask

	// Strobes drop on the next falling edge, so two calls never collide
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge clk);
		addr = a;
		wdata = d;
		sfr_wr = 1'b1;
		@(negedge clk);
		sfr_wr = 1'b0;
	endtask

	task automatic rd(input logic [7:0] a, input logic [7:0] exp);
		@(negedge clk);
		addr = a;
		sfr_rd = 1'b1;
		@(negedge clk);
		sfr_rd = 1'b0;
		check(16'(rvalid), 16'h0001);
		check(16'(rdata), 16'(exp));
	endtask

	task automatic pulse_tick;
		@(negedge clk);
		tick = 1'b1;
		@(negedge clk);
		tick = 1'b0;
	endtask

	// ==========================================================
	// Main sequence
	initial
	begin
		logic [15:0] mask;
		logic [7:0]  pat;
		repeat (8) @(posedge clk);
		@(negedge clk);
		check(count, 16'h0000);
		check(16'(cen), 16'h0000);
		check(16'(match), 16'h0000);
		rst_n = 1'b1;
		rd(`ADDR_COUNTER_LOW, 8'h00);
		rd(`ADDR_COUNTER_HIGH, 8'h00);
		// Reload storage must not disturb the capture value behind it
		foreach (rows[i])
		begin
			pat = {rows[i].m, rows[i].hi, 4'ha};
			rd(rows[i].a, 8'h00);
			wr(rows[i].a, pat);
			check(16'(cen[rows[i].m]), 16'(rows[i].hi));
			rd(rows[i].a, pat);
			rsel = 1'b1;
			wr(rows[i].a, ~pat);
			check(16'(cen[rows[i].m]), 16'(rows[i].hi));
			rd(rows[i].a, ~pat);
			rsel = 1'b0;
			rd(rows[i].a, pat);
		end
		wr(`ADDR_MODULE0_MODE, 8'h00);
		check(16'(cen[0]), 16'h0000);
		wr(`ADDR_MODULE0_MODE, 8'h40);
		check(16'(cen[0]), 16'h0001);
		wr(`ADDR_CAPTURE5_LOW, 8'h11);
		wde = 1'b1;
		wr(`ADDR_MODULE5_MODE, 8'h40);
		check(16'(cen[5]), 16'h0000);
		rd(`ADDR_MODULE5_MODE, 8'h00);
		wr(`ADDR_CAPTURE5_HIGH, 8'h22);
		check(16'(cen[5]), 16'h0000);
		wr(`ADDR_COUNTER_LOW, 8'h55);
		wr(`ADDR_COUNTER_HIGH, 8'h66);
		check(count, 16'h0000);
		wde = 1'b0;
		wr(`ADDR_COUNTER_LOW, 8'hff);
		wr(`ADDR_COUNTER_HIGH, 8'h12);
		check(count, 16'h12ff);
		rd(`ADDR_COUNTER_LOW, 8'hff);
		pulse_tick();
		check(count, 16'h1300);
		rd(`ADDR_COUNTER_HIGH, 8'h12);
		rd(`ADDR_COUNTER_LOW, 8'h00);
		rd(`ADDR_COUNTER_HIGH, 8'h13);
		clk_en = 1'b0;
		pulse_tick();
		clk_en = 1'b1;
		check(count, 16'h1300);
		// Narrow compare sees the low byte only; wide compare sees all 16 bits
		wr(`ADDR_COUNTER_LOW, 8'h0a);
		@(negedge clk);
		check(16'(match), 16'h0001);
		wr(`ADDR_CAPTURE0_LOW, 8'h0a);
		@(negedge clk);
		check(16'(match), 16'h0000);
		wr(`ADDR_MODULE1_MODE, 8'hc0);
		wr(`ADDR_COUNTER_LOW, 8'h2a);
		@(negedge clk);
		check(16'(match), 16'h0000);
		wr(`ADDR_COUNTER_HIGH, 8'h3a);
		@(negedge clk);
		check(16'(match), 16'h0002);
		// Low read with a tick, then the high read at once: the pair stays coherent
		wr(`ADDR_COUNTER_LOW, 8'hff);
		@(negedge clk);
		addr = `ADDR_COUNTER_LOW;
		sfr_rd = 1'b1;
		tick = 1'b1;
		@(negedge clk);
		addr = `ADDR_COUNTER_HIGH;
		tick = 1'b0;
		check(16'(rdata), 16'h00ff);
		@(negedge clk);
		sfr_rd = 1'b0;
		check(16'(rvalid), 16'h0001);
		check(16'(rdata), 16'h003a);
		check(count, 16'h3b00);
		// Channel 2 in narrow PWM takes its reload value at every cycle end
		wr(`ADDR_MODULE2_MODE, 8'h42);
		wr(8'h01, 8'h77);
		rd(8'h01, 8'h00);
		// Half mask first: a wrong cycle length would wrap there
		for (int c = 0; c < 4; c++)
		begin
			clsel = 2'(c);
			for (int k = 0; k < 2; k++)
			begin
				mask = (k == 1) ? (16'hffff >> (8 - c)) : (16'hffff >> (9 - c));
				wr(`ADDR_COUNTER_LOW, mask[7:0]);
				wr(`ADDR_COUNTER_HIGH, mask[15:8]);
				pulse_tick();
				check(16'(wrap), 16'(k));
				check(count, mask + 16'h0001);
			end
		end
		rd(`ADDR_CAPTURE2_LOW, 8'hb5);
		rd(`ADDR_CAPTURE2_HIGH, 8'ha5);
		@(negedge clk);
		rst_n = 1'b0;
		@(negedge clk);
		check(count, 16'h0000);
		check(16'(cen), 16'h0000);
		check(16'(match), 16'h0000);
		rst_n = 1'b1;
		rd(`ADDR_CAPTURE0_LOW, 8'h00);
		rd(`ADDR_COUNTER_HIGH, 8'h00);
		summarize();
	end

endmodule
`default_nettype wire
